/* File: hw/flash_config_word_loader.v */
// What this block does
// - programmed bit reads 0, erased reads 1
// - config registers at F80000h, table access only
// - reload words on every reset type
// - word1 at top address, word2 two below
// - unpack words into four of the five config locations
// - bit14 enables scan port, scan writes cannot clear it
// - bit13 zero protects whole program memory
// - bit12 zero blocks program memory writes
// - bit11 zero resets into debug mode
// - bit8 one selects second emulator pin pair
// - bit15 unknown, bit10 one, unimplemented read one
// - bit7 one turns watchdog on
// - bit6 zero windowed, valid only when enabled
// - bit4 selects prescale 128 or 32
// - bits3-0 give postscale two to power
// - fields readable, program-once, default ones
`timescale 1ns/100ps
`include "cfg_loader_defs.vh"
module flash_config_word_loader (
	input wire clk,
	input wire srst,
	input wire [23:0] flash_top_addr,
	output reg [23:0] flash_addr,
	output reg flash_rd,
	input wire flash_rd_valid,
	input wire [23:0] flash_rd_data,
	input wire tbl_rd,
	input wire tbl_wr,
	input wire tbl_from_scan,
	input wire [23:0] tbl_addr,
	input wire [23:0] tbl_wdata,
	output reg [23:0] tbl_rdata,
	output reg tbl_rd_valid,
	output wire cpu_hold_reset,
	output wire scan_port_enable,
	output wire general_code_protect,
	output wire general_write_protect,
	output wire debug_mode_entry,
	output wire emulator_pin_select,
	output wire emulator_pair_one,
	output wire emulator_pair_two,
	output wire watchdog_enable_cfg,
	output wire window_mode_disable,
	output wire watchdog_window_active,
	output wire watchdog_prescale_select,
	output wire [7:0] watchdog_prescale_ratio,
	output wire [3:0] watchdog_postscale_select,
	output wire [15:0] watchdog_postscale_ratio
);

// ----------------------------------------
// load sequencer
// ----------------------------------------
localparam ST_RD1 = 3'h0;
localparam ST_WT1 = 3'h1;
localparam ST_RD2 = 3'h2;
localparam ST_WT2 = 3'h3;
localparam ST_DONE = 3'h4;

reg [2:0] state_reg;
reg [2:0] state_next;
reg [23:0] word_one_reg;
reg [23:0] word_two_reg;
reg [23:0] loc_reg [0:4];
reg started_reg;

// srst covers every reset source, so each one reruns the load
always @(posedge clk) begin
	if (srst) begin
		state_reg <= ST_RD1;
		started_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		started_reg <= 1'b1;
	end
end

always @* begin
	state_next = state_reg;
	case (state_reg)
		ST_RD1: state_next = ST_WT1;
		ST_WT1: if (flash_rd_valid) state_next = ST_RD2;
		ST_RD2: state_next = ST_WT2;
		ST_WT2: if (flash_rd_valid) state_next = ST_DONE;
		ST_DONE: state_next = ST_DONE;
		default: state_next = ST_RD1;
	endcase
end

always @(posedge clk) begin
	if (srst) begin
		flash_rd <= 1'b0;
		flash_addr <= 24'h000000;
	end else begin
		flash_rd <= (state_reg == ST_RD1) || (state_reg == ST_RD2);
		if (state_reg == ST_RD1)
			flash_addr <= flash_top_addr;
		else if (state_reg == ST_RD2)
			flash_addr <= flash_top_addr - `WORD_TWO_BELOW;
	end
end

// processor leaves reset as word two is captured, a cycle before locations 2 and 3 carry it
assign cpu_hold_reset = srst || (state_reg != ST_DONE) || !started_reg;

// unimplemented positions read back as ones whatever the flash holds
always @(posedge clk) begin
	if (srst) begin
		word_one_reg <= `CFG_ERASED;
		word_two_reg <= `CFG_ERASED;
	end else if (flash_rd_valid && state_reg == ST_WT1) begin
		word_one_reg <= flash_rd_data | `W1_FORCE_ONE;
	end else if (flash_rd_valid && state_reg == ST_WT2) begin
		word_two_reg <= flash_rd_data | `W2_FORCE_ONE;
	end else if (tbl_wr && state_reg == ST_DONE && tbl_addr == `CFG_SPACE_BASE) begin
		// program-once: a write can only clear erased bits, never set them
		word_one_reg <= (word_one_reg & (tbl_wdata | `W1_FORCE_ONE))
			| (tbl_from_scan ? (word_one_reg & 24'h004000) : 24'h000000)
			| (24'h004000 & word_one_reg & {24{tbl_from_scan}});
	end
end

// ----------------------------------------
// five configuration space locations
// ----------------------------------------
genvar gi;
generate
	for (gi = 0; gi < 5; gi = gi + 1) begin : g_loc
		always @(posedge clk) begin
			if (srst)
				loc_reg[gi] <= `CFG_ERASED;
			else if (gi == 0)
				loc_reg[gi] <= {8'hFF, word_one_reg[15:8], 8'hFF};
			else if (gi == 1)
				loc_reg[gi] <= {16'hFFFF, word_one_reg[7:0]};
			else if (gi == 2)
				loc_reg[gi] <= {8'hFF, word_two_reg[15:8], 8'hFF};
			else if (gi == 3)
				loc_reg[gi] <= {16'hFFFF, word_two_reg[7:0]};
			else
				loc_reg[gi] <= `CFG_ERASED;
		end
	end
endgenerate

// ----------------------------------------
// table read port, configuration space only
// ----------------------------------------
wire in_cfg = (tbl_addr >= `CFG_SPACE_BASE) &&
	(tbl_addr < `CFG_SPACE_BASE + {21'h000000, `CFG_LOC_COUNT} * `CFG_LOC_STEP);
wire [23:0] loc_off = tbl_addr - `CFG_SPACE_BASE;

always @(posedge clk) begin
	if (srst) begin
		tbl_rdata <= 24'h000000;
		tbl_rd_valid <= 1'b0;
	end else begin
		tbl_rd_valid <= tbl_rd;
		if (tbl_rd && in_cfg)
			tbl_rdata <= loc_reg[loc_off[3:1]];
		else if (tbl_rd)
			tbl_rdata <= 24'h000000;
	end
end

// ----------------------------------------
// decoded fields
// ----------------------------------------
assign scan_port_enable = word_one_reg[`W1_SCAN_EN];
assign general_code_protect = ~word_one_reg[`W1_CODE_PROT];
assign general_write_protect = ~word_one_reg[`W1_WRITE_PROT];
assign debug_mode_entry = ~word_one_reg[`W1_DEBUG_SEL];
assign emulator_pin_select = word_one_reg[`W1_EMU_SEL];
assign emulator_pair_two = word_one_reg[`W1_EMU_SEL];
assign emulator_pair_one = ~word_one_reg[`W1_EMU_SEL];
assign watchdog_enable_cfg = word_one_reg[`W1_WDT_EN];
assign window_mode_disable = word_one_reg[`W1_WIN_DIS];
// window mode without the enable is not a legal combination, so it stays off
assign watchdog_window_active = watchdog_enable_cfg & ~window_mode_disable;
assign watchdog_prescale_select = word_one_reg[`W1_WDT_PRE];
assign watchdog_prescale_ratio = watchdog_prescale_select ? `PRESCALE_HI : `PRESCALE_LO;
assign watchdog_postscale_select = word_one_reg[`W1_POST_HI:`W1_POST_LO];
assign watchdog_postscale_ratio = 16'h0001 << watchdog_postscale_select;

endmodule // flash_config_word_loader

/* File: hw/cfg_loader_defs.vh */
`ifndef CFG_LOADER_DEFS_VH
`define CFG_LOADER_DEFS_VH
// ----------------------------------------
// flash geometry and configuration space
// ----------------------------------------
`define FADDR_W 24
`define CFG_WORD_W 24
`define CFG_SPACE_LO 24'h800000
`define CFG_SPACE_BASE 24'hF80000
`define WORD_TWO_BELOW 24'h000002
`define TOP_ADDR_64K 24'h00ABFE
`define TOP_ADDR_96K 24'h00FFFE
`define TOP_ADDR_128K 24'h0157FE
// five configuration register locations, word index from base (x2 address step)
`define CFG_LOC_COUNT 3'h5
`define CFG_LOC_STEP 24'h000002
// ----------------------------------------
// word 1 field positions
// ----------------------------------------
`define W1_RSVD_ZERO 15
`define W1_SCAN_EN 14
`define W1_CODE_PROT 13
`define W1_WRITE_PROT 12
`define W1_DEBUG_SEL 11
`define W1_RSVD_ONE 10
`define W1_UNIMPL_9 9
`define W1_EMU_SEL 8
`define W1_WDT_EN 7
`define W1_WIN_DIS 6
`define W1_UNIMPL_5 5
`define W1_WDT_PRE 4
`define W1_POST_HI 3
`define W1_POST_LO 0
// erased state reads all ones
`define CFG_ERASED 24'hFFFFFF
// masks of bits that read back forced to one: word 1 23-16, 9, 5; word 2 23-16, 14-11, 4-2
`define W1_FORCE_ONE 24'hFF0220
`define W2_FORCE_ONE 24'hFF781C
`define PRESCALE_HI 8'h80
`define PRESCALE_LO 8'h20
`endif

/* File: test/flash_model.sv */
`timescale 1ns/100ps
module flash_model (
	input wire clk,
	input wire [23:0] flash_top_addr,
	input wire [23:0] flash_addr,
	input wire flash_rd,
	input wire [23:0] w1,
	input wire [23:0] w2,
	input wire [3:0] lat,
	output reg flash_rd_valid = 1'b0,
	output reg [23:0] flash_rd_data = 24'h0
);
	reg [3:0] cnt_reg = 4'h0;
	// idle data toggles so a stale word is never taken for an answer
	always @(posedge clk) begin
		flash_rd_valid <= cnt_reg == 4'h1;
		flash_rd_data <= cnt_reg != 4'h1 ? ~flash_rd_data : flash_addr == flash_top_addr ? w1 : w2;
		cnt_reg <= flash_rd ? lat : cnt_reg - {3'h0, cnt_reg != 4'h0};
	end
endmodule // flash_model

/* File: test/flash_config_word_loader_sva.sv */
`timescale 1ns/100ps
module flash_config_word_loader_sva (
	input wire clk,
	input wire srst,
	input wire [23:0] flash_top_addr,
	input wire [23:0] flash_addr,
	input wire flash_rd,
	input wire tbl_rd,
	input wire tbl_rd_valid,
	input wire cpu_hold_reset,
	input wire watchdog_prescale_select,
	input wire [7:0] watchdog_prescale_ratio
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence top_read;
		flash_rd && flash_addr == flash_top_addr;
	endsequence
	a_read_addr: assert property (flash_rd |-> top_read or flash_addr == flash_top_addr - 24'h2) else $error("bad addr");
	a_read_pulse: assert property (flash_rd |=> !flash_rd) else $error("read not a pulse");
	a_read_held: assert property (top_read |-> cpu_hold_reset) else $error("cpu not held");
	a_no_reload: assert property (!cpu_hold_reset |=> !cpu_hold_reset && !flash_rd) else $error("reload");
	a_rd_answer: assert property (tbl_rd && !cpu_hold_reset |=> tbl_rd_valid) else $error("no answer");
	a_valid_pulse: assert property (!tbl_rd |=> !tbl_rd_valid) else $error("stray valid");
	a_pre_ratio: assert property (watchdog_prescale_ratio == (watchdog_prescale_select ? 8'h80 : 8'h20)) else $error("pre");
	a_once_only: assert property (!cpu_hold_reset && !watchdog_prescale_select |=> !watchdog_prescale_select) else $error("set");
endmodule // flash_config_word_loader_sva
bind flash_config_word_loader flash_config_word_loader_sva flash_config_word_loader_sva_i (.*);

/* File: test/testbench.sv */
`timescale 1ns/100ps
`include "cfg_loader_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
	reg clk = 1'b0, srst = 1'b1, tbl_rd = 1'b0, tbl_wr = 1'b0, tbl_from_scan = 1'b0;
	reg [23:0] flash_top_addr = `TOP_ADDR_64K, tbl_addr = 24'h0, tbl_wdata = 24'h0, w1 = `CFG_ERASED, w2 = `CFG_ERASED;
	reg [3:0] lat = 4'h1;
	wire [23:0] flash_addr, flash_rd_data, tbl_rdata;
	wire flash_rd, flash_rd_valid, tbl_rd_valid, cpu_hold_reset, scan_port_enable, general_code_protect;
	wire general_write_protect, debug_mode_entry, emulator_pin_select, emulator_pair_one, emulator_pair_two;
	wire watchdog_enable_cfg, window_mode_disable, watchdog_window_active, watchdog_prescale_select;
	wire [7:0] watchdog_prescale_ratio;
	wire [3:0] watchdog_postscale_select;
	wire [15:0] watchdog_postscale_ratio;
	wire [31:0] dec_got = {scan_port_enable, general_code_protect, general_write_protect, debug_mode_entry,
		emulator_pair_two, emulator_pair_one, watchdog_enable_cfg, watchdog_window_active, watchdog_prescale_ratio,
		watchdog_postscale_ratio};
	integer err_count = 0, checked = 0, i, k;
	flash_config_word_loader flash_config_word_loader_i (.*);
	flash_model flash_model_i (.*);
	initial forever #5 clk = ~clk;
	task tally_and_finish;
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task step(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task boot;
		srst = 1'b1;
		step(4);
		srst = 1'b0;
		for (k = 0; k < 99 && cpu_hold_reset !== 1'b0; k++)
			step(1);
		if (cpu_hold_reset !== 1'b0) begin
			err_count++;
			tally_and_finish;
		end
	endtask
	task tbl(input [23:0] a, input [23:0] d, input rd, input scan);
		{tbl_addr, tbl_wdata, tbl_from_scan, tbl_rd, tbl_wr} = {a, d, scan, rd, !rd};
		step(1);
		`CHK("tvalid", rd, tbl_rd_valid)
		{tbl_rd, tbl_wr} = 2'b00;
		step(2);
	endtask
	task dec;
		`CHK("dec", {w1[14], ~w1[13:11], w1[8], ~w1[8], w1[7], w1[7] & ~w1[6], (w1[4] ? 8'h80 : 8'h20), 16'h1 << w1[3:0]}, dec_got)
		`CHK("sel", {w1[8], w1[6], w1[4], w1[3:0]}, {emulator_pin_select, window_mode_disable, watchdog_prescale_select, watchdog_postscale_select})
	endtask
	initial begin
		boot;
		dec;
		tbl(24'h000100, 24'h0, 1'b1, 1'b0);
		`CHK("out", 24'h0, tbl_rdata)
		tbl(`CFG_SPACE_BASE, 24'hFFFF7F, 1'b0, 1'b0);
		tbl(`CFG_SPACE_BASE, `CFG_ERASED, 1'b0, 1'b0);
		`CHK("once", 1'b0, watchdog_enable_cfg)
		tbl(`CFG_SPACE_BASE, 24'hFFBFFF, 1'b0, 1'b1);
		`CHK("scan", 1'b1, scan_port_enable)
		// every pass resets again, so each new word proves a reload
		for (i = 0; i < 16; i++) begin
			flash_top_addr = i % 3 == 0 ? `TOP_ADDR_64K : i % 3 == 1 ? `TOP_ADDR_96K : `TOP_ADDR_128K;
			lat = i[1:0] + 4'h1;
			w1 = {8'hFF, 1'b0, i[0], i[1], i[2], i[3], 2'b11, ~i[0], i[1], ~i[2], 1'b1, ~i[3], i[3:0]};
			w2 = ~w1 | `W2_FORCE_ONE;
			boot;
			dec;
			`CHK("addr", flash_top_addr - `WORD_TWO_BELOW, flash_addr)
			tbl(`CFG_SPACE_BASE, 24'h0, 1'b1, 1'b0);
			`CHK("loc0", {8'hFF, w1[15:8], 8'hFF}, tbl_rdata)
			tbl(`CFG_SPACE_BASE + 24'h2, 24'h0, 1'b1, 1'b0);
			`CHK("loc1", {16'hFFFF, w1[7:0]}, tbl_rdata)
			tbl(`CFG_SPACE_BASE + 24'h4, 24'h0, 1'b1, 1'b0);
			`CHK("loc2", {8'hFF, w2[15:8], 8'hFF}, tbl_rdata)
			tbl(`CFG_SPACE_BASE + 24'h8, 24'h0, 1'b1, 1'b0);
			`CHK("loc4", `CFG_ERASED, tbl_rdata)
		end
		tally_and_finish;
	end
endmodule // testbench
